// ---- core/fbus_pkg.sv ----
/*
  shared constants for the fieldbus command word decoder: word widths,
  register numbering, command bit positions, profile codes, timing.
  assumes a single 100 mhz clock domain.
*/
package fbus_pkg;
  localparam int unsigned WORD_W        = 32;
  localparam int unsigned SHORT_W       = 16;
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned NUM_DATA_IO   = 14;
  localparam int unsigned FIFO_DEPTH    = 8;
  localparam int unsigned FIFO_W        = 1 + ADDR_W + WORD_W; // wide flag, address, data

  // holding register numbering, 6-digit and legacy 5-digit forms
  localparam int unsigned HREG6_BASE    = 400001;
  localparam int unsigned HREG6_LAST    = 465536;
  localparam int unsigned HREG5_BASE    = 40001;
  localparam int unsigned HREG5_LAST    = 49999;
  localparam int unsigned HREG5_REACH   = 409999;

  // register offsets in the 16-bit holding register field
  localparam logic [ADDR_W-1:0] REG_COMMAND_WORD = 16'h0000;
  localparam logic [ADDR_W-1:0] REG_REF_ONE      = 16'h0001;
  localparam logic [ADDR_W-1:0] REG_REF_TWO      = 16'h0002;
  localparam logic [ADDR_W-1:0] REG_STATUS       = 16'h0003;
  localparam logic [ADDR_W-1:0] REG_ACT_ONE      = 16'h0004;
  localparam logic [ADDR_W-1:0] REG_ACT_TWO      = 16'h0005;
  localparam logic [ADDR_W-1:0] REG_DATA_IO_BASE = 16'h0010;
  localparam logic [ADDR_W-1:0] REG_WIDE_BASE    = 16'h2000; // 32-bit parameters

  // command word bit positions
  localparam int unsigned CMD_RAMP_STOP   = 0;
  localparam int unsigned CMD_COAST_STOP  = 1;
  localparam int unsigned CMD_QUICK_STOP  = 2;
  localparam int unsigned CMD_RUN         = 3;
  localparam int unsigned CMD_RAMP_OUT    = 4;
  localparam int unsigned CMD_RAMP_HOLD   = 5;
  localparam int unsigned CMD_RAMP_IN     = 6;
  localparam int unsigned CMD_FAULT_RESET = 7;

  localparam logic PROFILE_CONVERTING   = 1'b0;
  localparam logic PROFILE_PASS_THROUGH = 1'b1;

  // quick stop time default and its cycle count at 100 mhz
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned QUICK_STOP_US    = 1000;
  localparam int unsigned QUICK_STOP_CYCLES = QUICK_STOP_US * CLK_MHZ;
  localparam int unsigned SAVE_CYCLES      = 4;

  typedef enum logic [2:0] {
    ST_START_BLOCKED = 3'b000,
    ST_READY_SWITCH  = 3'b001,
    ST_READY_OPERATE = 3'b011,
    ST_OP_ENABLED    = 3'b010,
    ST_RAMP_STOP     = 3'b110,
    ST_QUICK_STOP    = 3'b111,
    ST_COAST_STOP    = 3'b101,
    ST_FAULT         = 3'b100
  } drive_state_e;
endpackage

// ---- core/word_fifo.sv ----
/*
  small synchronous fifo with valid and ready on both sides.
  assumes one clock and a synchronised active low reset.
*/
module word_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_sync_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  assign in_ready  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_ff[rd_ptr_ff];

  // storage has no reset; only the pointers define contents
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---- core/cmd_word_decoder.sv ----
/*
  embedded link slave logic: keeps the command word, references and data
  words written over the link, answers reads, decodes stop, run and ramp.
  assumes link framing outside, one checked access per strobe, 100 mhz clock.
*/
// Operation
// - words are 16 bits, 32 under pass-through with wide mode
// - references held as signed 16 or 32 bits
// - two signed actual values returned to master
// - fourteen data words each bound to address
// - register address field is 16 bits
// - six-digit numbers 400001 to 465536 map
// - wide parameters hidden from five-digit numbering
// - converting or pass-through profile selectable
// - command word drives state changes
// - status word copied or converted per profile
// - bit0 low ramps down to ready-to-switch
// - bit1 low coasts, then start blocked
// - bit2 low quick-stops in time, blocked
// - bit3 enables operation given run enable
// - bit3 drives run enable when bus-sourced
// - bit4 low forces ramp output zero
// - bit5 low freezes ramp output
// - bit6 low zeros ramp input if bus-sourced
// - reference scaling chosen by reference type
// - save copies changes, then returns done
// - pass-through copies word to bits 0-15
// - bit7 rising edge clears fault, blocks start
module cmd_word_decoder
  import fbus_pkg::*;
#(
  parameter int unsigned QUICK_STOP_CNT = QUICK_STOP_CYCLES
) (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // link side register access
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic                     reg_wide,
  input  wire logic                     reg_legacy,
  input  wire logic [ADDR_W-1:0]        reg_addr,
  input  wire logic [WORD_W-1:0]        reg_wdata,
  output logic                          reg_ready,
  output logic      [WORD_W-1:0]        reg_rdata,
  output logic                          reg_rvalid,
  output logic                          reg_err,
  // configuration
  input  wire logic                     profile_sel,
  input  wire logic                     wide_mode,
  input  wire logic                     ref1_scaled,
  input  wire logic                     ref2_scaled,
  input  wire logic                     run_from_bus,
  input  wire logic                     ramp_in_from_bus,
  input  wire logic                     run_enable_in,
  input  wire logic                     fault_in,
  input  wire logic                     stopped_in,
  input  wire logic                     save_req,
  input  wire logic [ADDR_W-1:0]        data_io_map [NUM_DATA_IO],
  // drive side
  input  wire logic [WORD_W-1:0]        drive_status,
  input  wire logic [WORD_W-1:0]        actual_value_one,
  input  wire logic [WORD_W-1:0]        actual_value_two,
  input  wire logic [WORD_W-1:0]        data_io_rd [NUM_DATA_IO],
  output logic      [WORD_W-1:0]        internal_command,
  output logic      [WORD_W-1:0]        reference_one,
  output logic      [WORD_W-1:0]        reference_two,
  output logic                          ref1_scale_en,
  output logic                          ref2_scale_en,
  output logic      [NUM_DATA_IO-1:0]   data_io_wr,
  output logic      [ADDR_W-1:0]        data_io_addr,
  output logic      [WORD_W-1:0]        data_io_wdata,
  output logic                          ramp_stop_n,
  output logic                          coast_stop_n,
  output logic                          quick_stop_n,
  output logic                          run_enable_out,
  output logic                          ramp_out_zero,
  output logic                          ramp_hold,
  output logic                          ramp_in_zero,
  output logic                          fault_clear,
  output logic                          save_busy,
  output logic                          save_done,
  output logic      [2:0]               drive_state
);
  logic                    rst_meta_ff;
  logic                    rst_sync_ff;
  logic                    fifo_out_valid;
  logic                    fifo_out_ready;
  logic [FIFO_W-1:0]       fifo_out_data;
  logic                    wr_wide;
  logic [ADDR_W-1:0]       wr_addr;
  logic [WORD_W-1:0]       wr_data;
  logic                    addr_ok;
  logic [WORD_W-1:0]       command_word_ff;
  logic [WORD_W-1:0]       ref_one_ff;
  logic [WORD_W-1:0]       ref_two_ff;
  logic [WORD_W-1:0]       data_wdata_ff;
  logic [ADDR_W-1:0]       data_addr_ff;
  logic [NUM_DATA_IO-1:0]  data_wr_ff;
  logic [NUM_DATA_IO-1:0]  data_hit;
  logic [WORD_W-1:0]       rdata_ff;
  logic                    rvalid_ff;
  logic                    err_ff;
  logic                    reset_bit_ff;
  logic                    fault_clear_ff;
  logic [31:0]             qs_cnt_ff;
  logic [2:0]              save_cnt_ff;
  logic                    save_busy_ff;
  logic                    save_done_ff;
  logic                    run_ok;
  logic [WORD_W-1:0]       mask;
  drive_state_e            state_ff;
  drive_state_e            nxt_state;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // word width follows profile and wide mode: narrow words are zero extended
  assign mask = (wide_mode && profile_sel == PROFILE_PASS_THROUGH) ? '1 :
                {{(WORD_W-SHORT_W){1'b0}}, {SHORT_W{1'b1}}};
  // legacy five-digit masters cannot see wide parameter registers
  assign addr_ok = !(reg_legacy && (reg_wide || reg_addr >= REG_WIDE_BASE));

  // writes queue in the fifo so a link burst is never lost; reg_ready pushes back
  word_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
    .clk        (clk),
    .rst_sync_b (rst_sync_ff),
    .in_valid   (reg_wr && addr_ok),
    .in_ready   (reg_ready),
    .in_data    ({reg_wide, reg_addr, reg_wdata & mask}),
    .out_valid  (fifo_out_valid),
    .out_ready  (fifo_out_ready),
    .out_data   (fifo_out_data)
  );

  assign fifo_out_ready = !save_busy_ff; // parameters are frozen while saving
  assign {wr_wide, wr_addr, wr_data} = fifo_out_data;

  // data words: each one sits at a fixed offset and forwards to a configured parameter address
  for (genvar i = 0; i < NUM_DATA_IO; i++) begin : g_dio
    assign data_hit[i] = (wr_addr == REG_DATA_IO_BASE + ADDR_W'(i));
  end

  // register writes drained from the fifo; only whole words take effect
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      command_word_ff <= '0;
      ref_one_ff      <= '0;
      ref_two_ff      <= '0;
      data_wr_ff      <= '0;
      data_addr_ff    <= '0;
      data_wdata_ff   <= '0;
    end else begin
      data_wr_ff <= '0;
      if (fifo_out_valid && fifo_out_ready) begin
        if (wr_addr == REG_COMMAND_WORD) begin
          command_word_ff <= wr_data;
        end else if (wr_addr == REG_REF_ONE) begin
          ref_one_ff <= wr_data;
        end else if (wr_addr == REG_REF_TWO) begin
          ref_two_ff <= wr_data;
        end else if (data_hit != '0) begin
          data_wr_ff    <= data_hit;
          data_addr_ff  <= data_io_map[wr_addr[3:0]];
          data_wdata_ff <= wr_data;
        end
      end
    end
  end

  // read port answers one cycle after the strobe
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rdata_ff  <= '0;
      rvalid_ff <= 1'b0;
      err_ff    <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd;
      err_ff    <= (reg_rd || reg_wr) && !addr_ok;
      if (reg_rd) begin
        if (!addr_ok) begin
          rdata_ff <= '0;
        end else if (reg_addr == REG_STATUS) begin
          rdata_ff <= (profile_sel == PROFILE_PASS_THROUGH) ?
                      drive_status & mask :
                      {{(WORD_W-SHORT_W){1'b0}}, drive_status[SHORT_W-1:0]};
        end else if (reg_addr == REG_ACT_ONE) begin
          rdata_ff <= actual_value_one & mask;
        end else if (reg_addr == REG_ACT_TWO) begin
          rdata_ff <= actual_value_two & mask;
        end else if (reg_addr >= REG_DATA_IO_BASE &&
                     reg_addr < REG_DATA_IO_BASE + ADDR_W'(NUM_DATA_IO)) begin
          rdata_ff <= data_io_rd[reg_addr[3:0]] & mask;
        end else begin
          rdata_ff <= '0;
        end
      end
    end
  end

  // pass-through copies the low half untouched; converting rebuilds the stop bits and the gated run bit
  always_comb begin
    internal_command = '0;
    if (profile_sel == PROFILE_PASS_THROUGH) begin
      internal_command[SHORT_W-1:0] = command_word_ff[SHORT_W-1:0];
    end else begin
      internal_command[CMD_RAMP_STOP]  = ramp_stop_n;
      internal_command[CMD_COAST_STOP] = coast_stop_n;
      internal_command[CMD_QUICK_STOP] = quick_stop_n;
      internal_command[CMD_RUN]        = run_ok;
    end
  end

  // fault reset acts on a rising edge of bit 7 only
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      reset_bit_ff   <= 1'b0;
      fault_clear_ff <= 1'b0;
    end else begin
      reset_bit_ff   <= command_word_ff[CMD_FAULT_RESET];
      fault_clear_ff <= (profile_sel == PROFILE_CONVERTING) &&
                        command_word_ff[CMD_FAULT_RESET] && !reset_bit_ff;
    end
  end

  assign ramp_stop_n    = command_word_ff[CMD_RAMP_STOP];
  assign coast_stop_n   = command_word_ff[CMD_COAST_STOP];
  assign quick_stop_n   = command_word_ff[CMD_QUICK_STOP];
  assign run_enable_out = run_from_bus && command_word_ff[CMD_RUN];
  assign run_ok         = command_word_ff[CMD_RUN] && (run_from_bus || run_enable_in);
  // ramp output controls act only while operation is enabled
  assign ramp_out_zero = (state_ff == ST_OP_ENABLED) && !command_word_ff[CMD_RAMP_OUT];
  assign ramp_hold     = (state_ff == ST_OP_ENABLED) && !command_word_ff[CMD_RAMP_HOLD];
  assign ramp_in_zero  = ramp_in_from_bus && !command_word_ff[CMD_RAMP_IN];

  // drive state walk: coast beats quick stop beats ramp stop
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_FAULT: begin
        if (fault_clear_ff) begin
          nxt_state = ST_START_BLOCKED;
        end
      end
      ST_COAST_STOP: nxt_state = ST_START_BLOCKED;
      ST_QUICK_STOP: begin
        if (!coast_stop_n) begin
          nxt_state = ST_COAST_STOP;
        end else if (stopped_in || qs_cnt_ff == '0) begin
          nxt_state = ST_START_BLOCKED;
        end
      end
      ST_RAMP_STOP: begin
        if (!coast_stop_n) begin
          nxt_state = ST_COAST_STOP;
        end else if (!quick_stop_n) begin
          nxt_state = ST_QUICK_STOP;
        end else if (stopped_in) begin
          nxt_state = ST_READY_SWITCH;
        end
      end
      ST_START_BLOCKED: begin
        if (coast_stop_n && quick_stop_n && !ramp_stop_n) begin
          nxt_state = ST_READY_SWITCH;
        end
      end
      ST_READY_SWITCH: begin
        if (!coast_stop_n) begin
          nxt_state = ST_COAST_STOP;
        end else if (!quick_stop_n) begin
          nxt_state = ST_QUICK_STOP;
        end else if (ramp_stop_n) begin
          nxt_state = ST_READY_OPERATE;
        end
      end
      ST_READY_OPERATE: begin
        if (!coast_stop_n) begin
          nxt_state = ST_COAST_STOP;
        end else if (!quick_stop_n) begin
          nxt_state = ST_QUICK_STOP;
        end else if (!ramp_stop_n) begin
          nxt_state = ST_READY_SWITCH;
        end else if (run_ok) begin
          nxt_state = ST_OP_ENABLED;
        end
      end
      ST_OP_ENABLED: begin
        if (!coast_stop_n) begin
          nxt_state = ST_COAST_STOP;
        end else if (!quick_stop_n) begin
          nxt_state = ST_QUICK_STOP;
        end else if (!ramp_stop_n) begin
          nxt_state = ST_RAMP_STOP;
        end else if (!run_ok) begin
          nxt_state = ST_READY_OPERATE;
        end
      end
      default: nxt_state = ST_START_BLOCKED;
    endcase
    if (fault_in) begin
      nxt_state = ST_FAULT;
    end
  end

  // state only moves under the converting profile
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff <= ST_START_BLOCKED;
    end else if (profile_sel == PROFILE_CONVERTING) begin
      state_ff <= nxt_state;
    end
  end

  // quick stop timer loads on entry and counts down while stopping
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      qs_cnt_ff <= '0;
    end else if (state_ff != ST_QUICK_STOP) begin
      qs_cnt_ff <= QUICK_STOP_CNT;
    end else if (qs_cnt_ff != '0) begin
      qs_cnt_ff <= qs_cnt_ff - 1'b1;
    end
  end

  // save holds the write drain for a few cycles, then reports done
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      save_cnt_ff  <= '0;
      save_busy_ff <= 1'b0;
      save_done_ff <= 1'b1;
    end else if (save_busy_ff) begin
      if (save_cnt_ff == 3'(SAVE_CYCLES - 1)) begin
        save_busy_ff <= 1'b0;
        save_done_ff <= 1'b1;
      end
      save_cnt_ff <= save_cnt_ff + 1'b1;
    end else if (save_req) begin
      save_busy_ff <= 1'b1;
      save_done_ff <= 1'b0;
      save_cnt_ff  <= '0;
    end
  end

  assign reg_rdata     = rdata_ff;
  assign reg_rvalid    = rvalid_ff;
  assign reg_err       = err_ff;
  assign reference_one = ref_one_ff & mask;
  assign reference_two = ref_two_ff & mask;
  assign ref1_scale_en = ref1_scaled && profile_sel == PROFILE_CONVERTING;
  assign ref2_scale_en = ref2_scaled && profile_sel == PROFILE_CONVERTING;
  assign data_io_wr    = data_wr_ff;
  assign data_io_addr  = data_addr_ff;
  assign data_io_wdata = data_wdata_ff;
  assign fault_clear   = fault_clear_ff;
  assign save_busy     = save_busy_ff;
  assign save_done     = save_done_ff;
  assign drive_state   = state_ff;
endmodule

// ---- testbench/cmd_word_chk.sv ----
/*
  port checker for the command word decoder.
  assumes it is bound onto cmd_word_decoder, one clock domain.
*/
module cmd_word_chk
  import fbus_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              reg_rd,
  input wire logic              reg_wr,
  input wire logic              reg_legacy,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic              reg_rvalid,
  input wire logic              reg_err,
  input wire logic              profile_sel,
  input wire logic              fault_in,
  input wire logic [WORD_W-1:0] internal_command,
  input wire logic              coast_stop_n,
  input wire logic              fault_clear,
  input wire logic              save_busy,
  input wire logic              save_done,
  input wire logic [2:0]        drive_state
);
  timeunit 1ns;
  timeprecision 100ps;

  // raw reset disables all; the internal copy lags it, but no traffic then
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  read_answer_a : assert property (
    reg_rd && !reg_legacy |=> reg_rvalid) else $error("read not answered");
  legacy_refuse_a : assert property (
    (reg_rd || reg_wr) && reg_legacy && reg_addr >= REG_WIDE_BASE |=> reg_err)
    else $error("wide register reached by short number");
  upper_unused_a : assert property (
    internal_command[31:16] == 16'h0) else $error("upper command bits set");
  // several samples so a slow path through the coast state is allowed
  coast_block_a : assert property (
    (!coast_stop_n && !fault_in && profile_sel == PROFILE_CONVERTING
     && drive_state != ST_FAULT)[*3] |-> drive_state == ST_START_BLOCKED)
    else $error("coast stop did not block start");
  fault_hold_a : assert property (
    (fault_in && profile_sel == PROFILE_CONVERTING && !fault_clear)[*2]
    |-> drive_state == ST_FAULT) else $error("fault not entered");
  clear_pulse_a : assert property (
    fault_clear |=> !fault_clear) else $error("fault clear too long");
  save_end_a : assert property (
    $fell(save_busy) |-> save_done) else $error("save not done");
  save_len_a : assert property (
    $rose(save_busy) |-> save_busy[*4] ##1 !save_busy)
    else $error("save length wrong");
endmodule

bind cmd_word_decoder cmd_word_chk chk_i (
  .clk, .rst_b, .reg_rd, .reg_wr, .reg_legacy, .reg_addr, .reg_rvalid, .reg_err,
  .profile_sel, .fault_in, .internal_command, .coast_stop_n, .fault_clear,
  .save_busy, .save_done, .drive_state
);

// ---- testbench/link_master.sv ----
/*
  fieldbus master model: turns holding register numbers into offsets and
  makes one strobed access at a time. assumes callers run 1 ns after clk.
*/
module link_master
  import fbus_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reg_ready,
  input  wire logic [WORD_W-1:0] reg_rdata,
  input  wire logic              reg_err,
  output logic                   reg_wr,
  output logic                   reg_rd,
  output logic                   reg_wide,
  output logic                   reg_legacy,
  output logic      [ADDR_W-1:0] reg_addr,
  output logic      [WORD_W-1:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wide = 1'b0;
    reg_legacy = 1'b0;
    reg_addr = 16'h0;
    reg_wdata = 32'h0;
  end

  // short numbers only reach the lowest 9999 registers
  task automatic put(input int num, input logic [WORD_W-1:0] d);
    reg_legacy = (num < HREG6_BASE);
    reg_addr = reg_legacy ? ADDR_W'(num - HREG5_BASE) : ADDR_W'(num - HREG6_BASE);
    reg_wide = (reg_addr >= REG_WIDE_BASE);
    reg_wdata = d;
  endtask

  // released lines show the inverse so stale values cannot pass
  task automatic drop();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask

  task automatic wr(input int num, input logic [WORD_W-1:0] d, output bit ok);
    put(num, d);
    reg_wr = 1'b1;
    for (int n = 0; n < 64 && !reg_ready; n++) @(posedge clk) #1;
    ok = reg_ready;
    @(posedge clk);
    #1 drop();
  endtask

  // answer is registered at the taking edge, so it is settled 1 ns later
  task automatic rd(input int num, output logic [WORD_W-1:0] q, output logic e);
    put(num, 32'h0);
    reg_rd = 1'b1;
    @(posedge clk);
    #1 drop();
    q = reg_rdata;
    e = reg_err;
    @(posedge clk);
    #1;
  endtask
endmodule

// ---- testbench/testbench.sv ----
/*
  self-checking bench for the command word decoder.
  assumes the package, fifo and decoder are compiled first.
*/
module testbench
  import fbus_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic                 clk = 1'b0;
  logic                 rst_b = 1'b0;
  logic [9:0]           cfg = 10'h0; // bit 9 save request, 8..0 config levels
  logic                 reg_wr, reg_rd, reg_wide, reg_legacy, reg_ready;
  logic                 reg_rvalid, reg_err, ref1_scale_en, ref2_scale_en;
  logic                 ramp_stop_n, coast_stop_n, quick_stop_n, run_enable_out;
  logic                 ramp_out_zero, ramp_hold, ramp_in_zero, fault_clear;
  logic                 save_busy, save_done;
  logic [2:0]           drive_state;
  logic [ADDR_W-1:0]    reg_addr, data_io_addr;
  logic [ADDR_W-1:0]    data_io_map [NUM_DATA_IO];
  logic [WORD_W-1:0]    data_io_rd [NUM_DATA_IO];
  logic [WORD_W-1:0]    reg_wdata, reg_rdata, internal_command, data_io_wdata;
  logic [WORD_W-1:0]    reference_one, reference_two;
  logic [WORD_W-1:0]    drive_status = 32'h8765_4321;
  logic [WORD_W-1:0]    actual_value_one = 32'h1111_2222;
  logic [WORD_W-1:0]    actual_value_two = 32'h3333_4444;
  logic [NUM_DATA_IO-1:0] data_io_wr, io_hit = 14'h0;
  int                   err_count = 0, cmp_count = 0, clr_n = 0, busy_n = 0;

  always #5 clk = ~clk;

  cmd_word_decoder #(.QUICK_STOP_CNT(20)) dut (
    .clk, .rst_b, .reg_wr, .reg_rd, .reg_wide, .reg_legacy, .reg_addr, .reg_wdata,
    .reg_ready, .reg_rdata, .reg_rvalid, .reg_err, .profile_sel(cfg[0]),
    .wide_mode(cfg[1]), .ref1_scaled(cfg[2]), .ref2_scaled(cfg[3]),
    .run_from_bus(cfg[4]), .ramp_in_from_bus(cfg[5]), .run_enable_in(cfg[6]),
    .fault_in(cfg[7]), .stopped_in(cfg[8]), .save_req(cfg[9]), .data_io_map,
    .drive_status, .actual_value_one, .actual_value_two, .data_io_rd,
    .internal_command, .reference_one, .reference_two, .ref1_scale_en,
    .ref2_scale_en, .data_io_wr, .data_io_addr, .data_io_wdata, .ramp_stop_n,
    .coast_stop_n, .quick_stop_n, .run_enable_out, .ramp_out_zero, .ramp_hold,
    .ramp_in_zero, .fault_clear, .save_busy, .save_done, .drive_state
  );

  link_master m (
    .clk, .reg_ready, .reg_rdata, .reg_err, .reg_wr, .reg_rd, .reg_wide,
    .reg_legacy, .reg_addr, .reg_wdata
  );

  // clear pulses and busy cycles are counted and io strobes caught here, the sequence cannot sample them
  always @(posedge clk) begin
    if (fault_clear === 1'b1) clr_n++;
    if (save_busy === 1'b1) busy_n++;
    if (data_io_wr !== 14'h0) io_hit = data_io_wr;
  end

  // controls laid out at the command bit positions, each set as its command bit would be
  function automatic logic [WORD_W-1:0] ctl();
    return {25'h0, !ramp_in_zero, !ramp_hold, !ramp_out_zero, run_enable_out,
            quick_stop_n, coast_stop_n, ramp_stop_n};
  endfunction

  task automatic chk(input string what, input logic [WORD_W-1:0] exp,
                     input logic [WORD_W-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // register lands one cycle after being taken; one more for the state
  task automatic w(input int num, input logic [WORD_W-1:0] d);
    bit ok;
    m.wr(num, d, ok);
    chk("write taken", 32'h1, {31'h0, ok});
    idle(3);
  endtask

  task automatic r(input int num, input logic [WORD_W-1:0] exp, input logic e);
    logic [WORD_W-1:0] q;
    logic              qe;
    m.rd(num, q, qe);
    chk("read data", exp, q);
    chk("read error", {31'h0, e}, {31'h0, qe});
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    for (int i = 0; i < NUM_DATA_IO; i++) begin
      data_io_map[i] = 16'h0100 + 16'(i);
      data_io_rd[i] = 32'hd000_0000 + 32'(i);
    end
    idle(8);
    rst_b = 1'b1;
    idle(4);
    chk("state", ST_START_BLOCKED, drive_state);
    chk("save done", 32'h1, save_done);
    chk("controls", 32'h70, ctl());
    $display("test reset done");
    cfg = 10'h070;
    w(HREG6_BASE, 32'h7e);
    w(HREG6_BASE, 32'h7f);
    chk("run state", ST_OP_ENABLED, drive_state);
    // ramp output bits only act while operating, so clear bits from 6 down
    for (int i = 6; i >= 0; i--) begin
      w(HREG6_BASE, 32'h7f & ~(32'h1 << i));
      chk("controls", 32'h7f & ~(32'h1 << i), ctl());
    end
    cfg = 10'h000;
    w(HREG6_BASE, 32'h3f);
    chk("local controls", 32'h77, ctl());
    cfg = 10'h070;
    w(HREG6_BASE, 32'h7f);
    w(HREG6_BASE, 32'h7d);
    idle(3);
    chk("coast state", ST_START_BLOCKED, drive_state);
    $display("test command bits done");
    cfg = 10'h080;
    w(HREG6_BASE, 32'h0);
    chk("fault state", ST_FAULT, drive_state);
    cfg = 10'h000;
    w(HREG6_BASE, 32'h80);
    idle(2);
    chk("cleared state", ST_START_BLOCKED, drive_state);
    chk("clear pulses", 32'h1, clr_n);
    $display("test fault done");
    cfg = 10'h004;
    w(HREG6_BASE + 1, 32'h8001_2345);
    w(HREG6_BASE + 2, 32'h1234_fedc);
    w(HREG6_BASE + 19, 32'h5555_beef);
    chk("ref one", 32'h2345, reference_one);
    chk("ref two", 32'hfedc, reference_two);
    chk("scaling", 32'h2, {ref1_scale_en, ref2_scale_en});
    chk("io strobe", 32'h8, io_hit);
    chk("io addr", 32'h0103, data_io_addr);
    chk("io data", 32'hbeef, data_io_wdata);
    $display("test converting done");
    cfg = 10'h003;
    w(HREG6_BASE, 32'h0001_a5c3);
    chk("copied command", 32'ha5c3, internal_command);
    w(HREG6_BASE + 1, 32'h8000_0001);
    chk("wide ref", 32'h8000_0001, reference_one);
    r(HREG6_BASE + 3, drive_status, 1'b0);
    r(HREG6_BASE + 4, actual_value_one, 1'b0);
    r(HREG6_BASE + 5, actual_value_two, 1'b0);
    r(HREG6_BASE + 21, data_io_rd[5], 1'b0);
    r(HREG6_BASE + 256, 32'h0, 1'b0);
    r(HREG5_BASE + 4, actual_value_one, 1'b0);
    r(HREG5_BASE + 8192, 32'h0, 1'b1);
    $display("test pass-through done");
    cfg[9] = 1'b1;
    idle(1);
    cfg[9] = 1'b0;
    idle(8);
    chk("busy cycles", 32'h4, busy_n);
    chk("save done", 32'h1, save_done);
    $display("test save done");
    report_and_stop();
  end
endmodule
